// ==== hw/fsp_top.sv ====
`timescale 1ns/1ns
module fsp_top
    import fsp_pkg::*;
#(
    parameter int PAGE_WORD_BITS = 7,
    parameter int ADDR_BITS = 17,
    parameter int NONCONCURRENT_REGION_START = 17'h1E000,
    parameter int PROG_COUNT = PROG_CYCLES
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wdata_i,
    input wire logic ctrl_rd_i,
    output logic [7:0] ctrl_rdata_o,
    input wire fsp_ptr_t ptr_i,
    input wire logic store_i,
    input wire logic load_i,
    output logic [7:0] load_data_o,
    output logic load_valid_o,
    input wire logic [15:0] flash_rdata_i,
    input wire logic [7:0] fuse_lo_i,
    input wire logic [7:0] fuse_hi_i,
    input wire logic [7:0] fuse_ext_i,
    output logic [7:0] lock_bits_o,
    output logic [ADDR_BITS-1:0] prog_addr_o,
    output logic erase_o,
    output logic write_o,
    output logic [15:0] buf_data_o,
    output logic cpu_halt_o,
    output logic rww_block_o,
    output logic irq_o
);
    localparam int NWORDS = 1 << PAGE_WORD_BITS;

    typedef struct packed {
        fsp_state_t st;
        logic [2:0] win;
        logic [4:0] cmd;
        logic ie;
        logic busy;
        logic [31:0] cnt;
        logic erase;
        logic [ADDR_BITS-1:0] addr;
        logic [NWORDS-1:0][15:0] buffer;
        logic [NWORDS-1:0] filled;
        logic [7:0] lock;
        logic [7:0] rd;
        logic rd_v;
        logic [7:0] rdata;
        logic halt;
        logic irq;
        logic erase_act;
        logic write_act;
        logic [15:0] buf_word;
    } fsp_regs_t;

    fsp_regs_t q, next_q;

    // Byte address from pointer plus extension
    function automatic logic [ADDR_BITS-1:0] full_addr(input fsp_ptr_t p);
        logic [23:0] a;
        a = {p.pointer_page_extension, p.z};
        return a[ADDR_BITS-1:0];
    endfunction : full_addr

    function automatic logic [7:0] ctrl_view(input fsp_regs_t s);
        logic [7:0] v;
        v = 8'h00;
        v[BIT_IE] = s.ie;
        v[BIT_BUSY] = s.busy;
        v[4:0] = (s.st == FSP_IDLE) ? 5'h00 : s.cmd;
        return v;
    endfunction : ctrl_view

    // Only the five defined low-bit patterns arm anything
    function automatic logic is_cmd(input logic [4:0] c);
        return c inside {CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN};
    endfunction : is_cmd

    logic [ADDR_BITS-1:0] cur_addr;
    logic [PAGE_WORD_BITS-1:0] widx;
    assign cur_addr = full_addr(ptr_i);
    assign widx = cur_addr[PAGE_WORD_BITS:1];

    always_comb
    begin
        next_q = q;
        next_q.rd_v = 1'b0;
        if (ctrl_rd_i)
            next_q.rdata = ctrl_view(q);
        // ---------------------------------------------------------------
        // Arming window and command execution
        // ---------------------------------------------------------------
        unique case (q.st)
            FSP_IDLE:
            begin
                if (ctrl_wr_i)
                begin
                    next_q.ie = ctrl_wdata_i[BIT_IE];
                    if (is_cmd(ctrl_wdata_i[4:0]))
                    begin
                        next_q.st = FSP_ARMED;
                        next_q.cmd = ctrl_wdata_i[4:0];
                        next_q.win = STORE_WIN;
                    end
                end
            end
            FSP_ARMED:
            begin
                next_q.win = q.win - 3'h1;
                if (store_i)
                begin
                    next_q.st = FSP_IDLE;
                    unique case (q.cmd)
                        CMD_LOAD:
                        begin
                            // any order; rewriting a word is undefined
                            next_q.buffer[widx] = ptr_i.r10;
                            next_q.filled[widx] = 1'b1;
                            next_q.busy = 1'b0;
                        end
                        CMD_ERASE, CMD_WRITE:
                        begin
                            // Word bits dropped: page only
                            next_q.addr = cur_addr & ~ADDR_BITS'(2*NWORDS-1);
                            next_q.erase = (q.cmd == CMD_ERASE);
                            next_q.st = FSP_BUSY;
                            next_q.cnt = 32'(PROG_COUNT);
                            next_q.busy = 1'b1;
                            next_q.halt = (cur_addr >= ADDR_BITS'(NONCONCURRENT_REGION_START));
                        end
                        CMD_LOCK:
                        begin
                            next_q.lock[5:0] = q.lock[5:0] & ptr_i.r10[5:0];
                        end
                        default:
                        begin
                            // Reenable; only legal when idle
                            next_q.busy = 1'b0;
                            next_q.buffer = '0;
                            next_q.filled = '0;
                        end
                    endcase
                end
                else if (load_i && q.cmd == CMD_LOCK && q.win > (STORE_WIN - LOAD_WIN))
                begin
                    next_q.st = FSP_IDLE;
                    next_q.rd_v = 1'b1;
                    unique case (ptr_i.z)
                        ADDR_FUSE_LO: next_q.rd = fuse_lo_i;
                        ADDR_FUSE_HI: next_q.rd = fuse_hi_i;
                        ADDR_FUSE_EXT: next_q.rd = (fuse_ext_i & EXT_MASK) | ~EXT_MASK;
                        ADDR_LOCK: next_q.rd = q.lock;
                        default: next_q.rd = 8'hFF;
                    endcase
                end
                else if (q.win == 3'h1)
                    next_q.st = FSP_IDLE;
            end
            default:
            begin
                // FSP_BUSY
                next_q.cnt = q.cnt - 32'h1;
                if (q.cnt == 32'h1)
                begin
                    next_q.st = FSP_IDLE;
                    next_q.halt = 1'b0;
                    if (!q.erase)
                    begin
                        next_q.buffer = '0;
                        next_q.filled = '0;
                    end
                end
            end
        endcase
        if (load_i && !(q.st == FSP_ARMED && q.cmd == CMD_LOCK))
        begin
            next_q.rd_v = 1'b1;
            next_q.rd = ptr_i.z[0] ? flash_rdata_i[15:8] : flash_rdata_i[7:0];
        end
        next_q.irq = q.ie && (next_q.st != FSP_BUSY) && (next_q.st != FSP_ARMED);
        // Registered copies so every output leaves a flip-flop
        next_q.erase_act = (next_q.st == FSP_BUSY) && next_q.erase;
        next_q.write_act = (next_q.st == FSP_BUSY) && !next_q.erase;
        next_q.buf_word = next_q.buffer[next_q.addr[PAGE_WORD_BITS:1]];
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            q <= '0;
            q.lock <= 8'hFF;
        end
        else
            q <= next_q;
    end

    assign ctrl_rdata_o = q.rdata;
    assign load_data_o = q.rd;
    assign load_valid_o = q.rd_v;
    assign lock_bits_o = q.lock;
    assign prog_addr_o = q.addr;
    assign erase_o = q.erase_act;
    assign write_o = q.write_act;
    assign buf_data_o = q.buf_word;
    assign cpu_halt_o = q.halt;
    assign rww_block_o = q.busy;
    assign irq_o = q.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_busy_on_prog;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_BUSY) |-> q.busy;
    endproperty
    a_busy_on_prog: assert property (p_busy_on_prog) else $error("busy flag low in programming");
    property p_timeout;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.win == 3'h1 && !store_i && !load_i) |=> q.st == FSP_IDLE;
    endproperty
    a_timeout: assert property (p_timeout) else $error("arm window did not expire");
    property p_irq;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_BUSY) |-> !q.irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt during programming");
    property p_bad_cmd;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_IDLE && ctrl_wr_i && ctrl_wdata_i[4:0] == 5'h07) |=> q.st == FSP_IDLE;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("undefined pattern armed");

    // ---------------------------------------------------------------
    // Programming, readback and buffer checks
    // ---------------------------------------------------------------
    property p_halt_busy;
        @(posedge clk_i) disable iff (reset_i)
        q.halt |-> (q.st == FSP_BUSY);
    endproperty
    a_halt_busy: assert property (p_halt_busy) else $error("halt outside programming");

    property p_halt_region;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && store_i && (q.cmd == CMD_ERASE || q.cmd == CMD_WRITE)
            && cur_addr >= ADDR_BITS'(NONCONCURRENT_REGION_START)) |=> q.halt;
    endproperty
    a_halt_region: assert property (p_halt_region) else $error("no halt for region");

    property p_no_halt_rww;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && store_i && (q.cmd == CMD_ERASE || q.cmd == CMD_WRITE)
            && cur_addr < ADDR_BITS'(NONCONCURRENT_REGION_START)) |=> !q.halt;
    endproperty
    a_no_halt_rww: assert property (p_no_halt_rww) else $error("halt for other region");

    property p_addr_held;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_BUSY && $past(q.st) == FSP_BUSY) |-> $stable(q.addr);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved in op");

    property p_page_aligned;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_BUSY) |-> (q.addr[PAGE_WORD_BITS:0] == '0);
    endproperty
    a_page_aligned: assert property (p_page_aligned) else $error("address not a page");

    property p_en_held;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_BUSY && q.cnt != 32'h1) |=> (q.st == FSP_BUSY);
    endproperty
    a_en_held: assert property (p_en_held) else $error("operation ended early");

    property p_prog_ends;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_BUSY && q.cnt == 32'h1) |=> (q.st == FSP_IDLE && !q.halt);
    endproperty
    a_prog_ends: assert property (p_prog_ends) else $error("operation did not end");

    property p_load_answer;
        @(posedge clk_i) disable iff (reset_i)
        (load_i && !(q.st == FSP_ARMED && q.cmd == CMD_LOCK)) |=> q.rd_v;
    endproperty
    a_load_answer: assert property (p_load_answer) else $error("load not answered");

    property p_valid_pulse;
        @(posedge clk_i) disable iff (reset_i)
        q.rd_v |-> $past(load_i);
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid without load");

    property p_byte_sel;
        @(posedge clk_i) disable iff (reset_i)
        (load_i && q.st == FSP_IDLE) |=> (q.rd == ($past(ptr_i.z[0]) ?
            $past(flash_rdata_i[15:8]) : $past(flash_rdata_i[7:0])));
    endproperty
    a_byte_sel: assert property (p_byte_sel) else $error("wrong byte of word");

    property p_lock_read;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.cmd == CMD_LOCK && q.win > (STORE_WIN - LOAD_WIN)
            && load_i && !store_i && ptr_i.z == ADDR_LOCK) |=> (q.rd == $past(q.lock));
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock readback wrong");

    property p_fuse_lo;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.cmd == CMD_LOCK && q.win > (STORE_WIN - LOAD_WIN)
            && load_i && !store_i && ptr_i.z == ADDR_FUSE_LO) |=> (q.rd == $past(fuse_lo_i));
    endproperty
    a_fuse_lo: assert property (p_fuse_lo) else $error("fuse low readback wrong");

    property p_fuse_ext;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.cmd == CMD_LOCK && q.win > (STORE_WIN - LOAD_WIN)
            && load_i && !store_i && ptr_i.z == ADDR_FUSE_EXT) |=> ((q.rd & ~EXT_MASK) == ~EXT_MASK);
    endproperty
    a_fuse_ext: assert property (p_fuse_ext) else $error("undefined bits not one");

    property p_lock_prog;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.cmd == CMD_LOCK && store_i)
            |=> ((q.lock[5:0] & ~$past(ptr_i.r10[5:0])) == 6'h00);
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("lock bit not programmed");

    property p_lock_sticky;
        @(posedge clk_i) disable iff (reset_i)
        ((q.lock[5:0] & ~$past(q.lock[5:0])) == 6'h00) && (q.lock[7:6] == 2'b11);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit unprogrammed");

    property p_lock_free;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.cmd == CMD_LOCK && store_i)
            |=> (!q.halt && q.busy == $past(q.busy));
    endproperty
    a_lock_free: assert property (p_lock_free) else $error("lock write blocked flash");

    property p_reen;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.cmd == CMD_REEN && store_i) |=> (q.filled == '0 && !q.busy);
    endproperty
    a_reen: assert property (p_reen) else $error("reenable left buffer or busy");

    property p_write_clear;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_BUSY && !q.erase && q.cnt == 32'h1) |=> (q.filled == '0);
    endproperty
    a_write_clear: assert property (p_write_clear) else $error("buffer kept after write");

    property p_load_fill;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED && q.cmd == CMD_LOAD && store_i) |=> (q.filled[$past(widx)] && !q.busy);
    endproperty
    a_load_fill: assert property (p_load_fill) else $error("buffer word not loaded");

    property p_arm_valid;
        @(posedge clk_i) disable iff (reset_i)
        (q.st == FSP_ARMED) |-> (is_cmd(q.cmd) && q.win != 3'h0 && q.win <= STORE_WIN);
    endproperty
    a_arm_valid: assert property (p_arm_valid) else $error("bad armed state");

    property p_erase_out;
        @(posedge clk_i) disable iff (reset_i)
        q.erase_act |-> (q.busy && !q.write_act);
    endproperty
    a_erase_out: assert property (p_erase_out) else $error("erase without busy flag");

    property p_irq_level;
        @(posedge clk_i) disable iff (reset_i)
        ($past(q.ie) && q.st == FSP_IDLE) |-> q.irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("ready interrupt missing");
endmodule : fsp_top

// ==== hw/fsp_pkg.sv ====
// Functional notes
// - Address from pointer plus page extension register
// - Target address latched when operation starts
// - Program loads address bytes; bit0 picks byte
// - Pattern X0000011 then store erases page
// - Non-concurrent erase halts CPU; concurrent erase not
// - Pattern 00000001 then store loads buffer word
// - Buffer cleared after write, reenable, reset
// - Pattern X0000101 then store writes page
// - Non-concurrent write halts CPU until done
// - Buffer loads accepted in any order
// - Enabled ready interrupt high while enable clear
// - Erase/write blocks concurrent region, busy flag set
// - Pattern X0001001 then store programs lock bits
// - Lock programming blocks no flash region
// - Lock-set read at address 0001 returns locks
// - Lock-set/enable clear on read or timeout
// - Fuse read selects low, high, extended byte
// - Programmed bits read zero, unprogrammed read one
// - With bits clear, loads read flash normally
// - Undefined low five bit patterns are ignored
// - Enable bit stays set through erase/write
// - Reenable during loading discards loaded data
package fsp_pkg;
    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int BIT_EN = 0;
    localparam int BIT_ERS = 1;
    localparam int BIT_WRT = 2;
    localparam int BIT_LOCK = 3;
    localparam int BIT_REEN = 4;
    localparam int BIT_BUSY = 6;
    localparam int BIT_IE = 7;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REEN = 5'h11;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ---------------------------------------------------------------
    // Readback addresses and windows
    // ---------------------------------------------------------------
    localparam logic [15:0] ADDR_FUSE_LO = 16'h0000;
    localparam logic [15:0] ADDR_LOCK = 16'h0001;
    localparam logic [15:0] ADDR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] ADDR_FUSE_HI = 16'h0003;
    localparam logic [7:0] EXT_MASK = 8'h07;
    localparam logic [5:0] LOCK_MASK = 6'h3F;
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [2:0] LOAD_WIN = 3'h3;
    // Programming time, worst case figure
    localparam int PROG_TIME_US = 4500;
    localparam int CLK_MHZ = 50;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    // ---------------------------------------------------------------
    // Grouped carriers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_state_t;
    typedef struct packed {
        logic [7:0] pointer_page_extension;
        logic [15:0] z;
        logic [15:0] r10;
    } fsp_ptr_t;
endpackage : fsp_pkg

// ==== bench/fsp_flash_model.sv ====
`timescale 1ns/1ns
module fsp_flash_model
    import fsp_pkg::*;
(
    input wire fsp_ptr_t ptr_i,
    output logic [15:0] rdata_o
);
    // Two distinct bytes per word, so a wrong byte select shows up
    assign rdata_o = {ptr_i.z[8:1] ^ 8'h3C, ptr_i.z[8:1]};
endmodule : fsp_flash_model

// ==== bench/flash_self_programming_bench.sv ====
`timescale 1ns/1ns
module flash_self_programming_bench
    import fsp_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wr = 1'b0, rd = 1'b0, st = 1'b0, ld = 1'b0;
    logic [7:0] wd = 8'h00;
    fsp_ptr_t ptr = '0;
    logic [15:0] frd;
    logic [7:0] crd, ldd, lockb;
    logic ldv, ers, wrt, halt, blk, irq;
    logic [16:0] paddr;
    logic [15:0] bufw;
    int errors = 0;
    int n_checks = 0;
    always #10 clk_i = ~clk_i;
    fsp_flash_model u_flash (.ptr_i(ptr), .rdata_o(frd));
    fsp_top #(.PROG_COUNT(20)) u_dut (.clk_i(clk_i), .reset_i(reset_i), .ctrl_wr_i(wr),
        .ctrl_wdata_i(wd), .ctrl_rd_i(rd), .ctrl_rdata_o(crd), .ptr_i(ptr), .store_i(st),
        .load_i(ld), .load_data_o(ldd), .load_valid_o(ldv), .flash_rdata_i(frd),
        .fuse_lo_i(8'h6C), .fuse_hi_i(8'hD9), .fuse_ext_i(8'hFD), .lock_bits_o(lockb),
        .prog_addr_o(paddr), .erase_o(ers), .write_o(wrt), .buf_data_o(bufw),
        .cpu_halt_o(halt), .rww_block_o(blk), .irq_o(irq));
    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cwr(input logic [7:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        wd <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : cwr
    task automatic crd_chk(input logic [7:0] exp);
        @(posedge clk_i);
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk("ctrl", crd, exp);
    endtask : crd_chk
    task automatic store;
        st <= 1'b1;
        @(posedge clk_i);
        st <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : store
    // Checks only the bits in msk; undefined bits are left open
    task automatic load(input logic [7:0] exp, input logic [7:0] msk);
        ld <= 1'b1;
        @(posedge clk_i);
        ld <= 1'b0;
        #1;
        chk("valid", ldv, 1'b1);
        chk("ldata", ldd & msk, exp & msk);
    endtask : load
    task automatic wait_done;
        for (int i = 0; i < 60 && (ers === 1'b1 || wrt === 1'b1); i++)
            @(posedge clk_i);
        #1;
        chk("done", {ers, wrt}, 2'b00);
    endtask : wait_done
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        #40000;
        errors++;
        end_of_test();
    end
    initial
    begin
        logic [7:0] fx [4];
        fx = '{8'h6C, 8'hFF, 8'h05, 8'hD9};
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        crd_chk(8'h00);
        chk("locks", lockb, 8'hFF);
        chk("irq", irq, 1'b0);
        $display("test reset done");
        for (int a = 0; a < 4; a++)
        begin
            ptr.z <= 16'(a);
            cwr(8'h09);
            load(fx[a], a == 2 ? 8'h07 : 8'hFF);
        end
        $display("test fuse read done");
        cwr(8'h07);
        crd_chk(8'h00);
        cwr(8'h09);
        crd_chk(8'h09);
        repeat (5) @(posedge clk_i);
        crd_chk(8'h00);
        $display("test arming done");
        ptr.r10 <= 16'h00F2;
        cwr(8'h09);
        store();
        chk("locks", lockb, 8'hF2);
        chk("block", blk, 1'b0);
        ptr.z <= 16'h0001;
        cwr(8'h09);
        load(8'hF2, 8'hFF);
        ptr.z <= 16'h0043;
        @(posedge clk_i);
        load(8'h1D, 8'hFF);
        ptr.z <= 16'h0042;
        @(posedge clk_i);
        load(8'h21, 8'hFF);
        $display("test locks done");
        ptr.z <= 16'h1234;
        cwr(8'h03);
        store();
        ptr.z <= 16'hFFFF;
        chk("erase", {ers, blk, halt}, 3'b110);
        crd_chk(8'h43);
        chk("addr", paddr, 17'h01200);
        wait_done();
        chk("block", blk, 1'b1);
        cwr(8'h11);
        store();
        chk("block", blk, 1'b0);
        $display("test erase done");
        ptr.pointer_page_extension <= 8'h01;
        ptr.z <= 16'hE000;
        ptr.r10 <= 16'hA55A;
        cwr(8'h01);
        store();
        ptr.z <= 16'hE080;
        cwr(8'h05);
        store();
        chk("write", {wrt, halt}, 2'b11);
        chk("addr", paddr, 17'h1E000);
        chk("buf", bufw, 17'h0A55A);
        wait_done();
        chk("halt", halt, 1'b0);
        chk("buf", bufw, 17'h00000);
        cwr(8'h11);
        store();
        cwr(8'h80);
        @(posedge clk_i);
        #1;
        chk("irq", irq, 1'b1);
        $display("test write done");
        end_of_test();
    end
endmodule : flash_self_programming_bench
